// File: hdl/lbm_pkg.sv
// Package for the laser bias and modulation compensation block.
// Assumes one 40 MHz system clock; no other files are needed.
package lbm_pkg;

    // ==========================================================
    // Memory map of the two-wire slave port.
    localparam logic [7:0] OFS_POWER_LOOP_TARGET   = 8'h02;
    localparam logic [7:0] OFS_BIAS_TRACK_MOD_GAIN = 8'h04;
    localparam logic [7:0] OFS_THERMAL_MOD_SLOPE   = 8'h05;
    localparam logic [7:0] OFS_THERMAL_MOD_START   = 8'h06;
    localparam logic [7:0] OFS_MOD_SETTING         = 8'h07;
    localparam logic [7:0] OFS_BIAS_SETTING        = 8'h08;
    localparam logic [7:0] OFS_TRACKING_SLOPE      = 8'h09;
    localparam logic [7:0] OFS_TRACKING_START_TEMP = 8'h0A;
    localparam logic [7:0] OFS_LUT_FIRST           = 8'h10;
    localparam logic [7:0] OFS_LUT_LAST            = 8'h33;
    localparam logic [7:0] OFS_BIAS_READING_HI     = 8'h75;
    localparam logic [7:0] OFS_BIAS_READING_LO     = 8'h76;
    localparam logic [7:0] OFS_CAL_TEMP            = 8'h77;
    localparam logic [7:0] OFS_POWER_TARGET_OUT    = 8'h78;
    localparam logic [7:0] OFS_MOD_OUT             = 8'h79;
    localparam logic [7:0] OFS_BIAS_OUT            = 8'h7A;

    // ==========================================================
    // Sizes, steps and arithmetic constants.
    localparam int          LUT_DEPTH      = 36;
    localparam int          LUT_STEP_DEG   = 4;
    localparam int          HYST_DEG       = 2;
    localparam int          PERCENT        = 100;
    localparam int          READING_DIV    = 4;
    localparam logic [7:0]  PWM_FULL       = 8'hFF;
    localparam logic [7:0]  RESET_BYTE     = 8'h00;

    // ==========================================================
    // Timing: pre-charge settles within this time after enable.
    localparam int CLK_HZ         = 40_000_000;
    localparam int PRECHARGE_NS   = 600;
    localparam int PRECHARGE_CYC  =
        (PRECHARGE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // ==========================================================
    // Control states.
    typedef enum logic [1:0] {
        ST_OFF     = 2'b00,
        ST_PRELOAD = 2'b01,
        ST_SETTLE  = 2'b11,
        ST_RUN     = 2'b10
    } lbm_state_t;

    // Setting values handed to the laser driver.
    typedef struct packed {
        logic [7:0] biasPwm;
        logic [7:0] modPwm;
        logic [7:0] powerTarget;
    } lbm_drive_t;

endpackage : lbm_pkg

// File: hdl/lbm_compensation.sv
// Bias pre-charge, modulation boosts and power-loop set point scaling.
// Assumes an upstream two-wire slave decoder presents byte accesses
// and a monitor block supplies calibrated temperature and bias reading.
`timescale 1ns/100ps

module lbm_compensation #(
    parameter int LUT_ENTRIES = lbm_pkg::LUT_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              txEnable,
    input  wire logic [7:0]        calibratedTemperature,
    input  wire logic [15:0]       biasCurrentReading,
    input  wire logic              hostWrite,
    input  wire logic              hostRead,
    input  wire logic [7:0]        hostAddr,
    input  wire logic [7:0]        hostWdata,
    output logic      [7:0]        hostRdata,
    output logic                   initDone,
    output lbm_pkg::lbm_drive_t    drive
);

    // ==========================================================
    // Elaboration check on the table depth.
    // The table spans the byte map from its first to its last entry, so
    // any other depth would alias host addresses or leave entries that
    // the temperature index can reach without storage behind them.
    if (LUT_ENTRIES != lbm_pkg::LUT_DEPTH) begin : g_bad_depth
        $error("LUT_ENTRIES must match the table span");
    end

    // ==========================================================
    // Saturating and hysteresis helpers.
    // A signed sum is formed wide and clipped here, so a large boost pins
    // the code at a limit instead of wrapping round to a tiny current.
    function automatic logic [7:0] sat8(input logic signed [19:0] v);
        if (v < 0) begin
            sat8 = 8'h00;
        end else if (v > 20'sd255) begin
            sat8 = 8'hFF;
        end else begin
            sat8 = v[7:0];
        end
    endfunction : sat8

    // Hysteresis: follow only once the input moves two degrees away.
    // Without it a reading that dithers across a boost start point
    // would make the modulation code chatter by one step each sample.
    // The held value jumps straight to the new reading, not in steps.
    function automatic logic [7:0] hyst(input logic [7:0] held,
                                        input logic [7:0] now);
        logic [8:0] up;
        logic [8:0] dn;
        up = {1'b0, held} + 9'(lbm_pkg::HYST_DEG);
        dn = {1'b0, now} + 9'(lbm_pkg::HYST_DEG);
        if ({1'b0, now} >= up || dn <= {1'b0, held}) begin
            hyst = now;
        end else begin
            hyst = held;
        end
    endfunction : hyst

    // ==========================================================
    // Stored parameters and the bias table.
    // Every parameter byte resets to zero, so a cold part asks for no
    // current until the host has loaded its calibration.
    logic [7:0] powerLoopTarget;
    logic [7:0] biasTrackingModGain;
    logic [7:0] thermalModSlope;
    logic [7:0] thermalModStart;
    logic [7:0] modSetting;
    logic [7:0] biasSetting;
    logic [7:0] trackingSlope;
    logic [7:0] trackingStartTemp;
    logic [7:0] bias_lookup_table_base [LUT_ENTRIES];

    // Table addresses map one to one onto table entries.
    wire        lutHit  = hostAddr >= lbm_pkg::OFS_LUT_FIRST &&
                          hostAddr <= lbm_pkg::OFS_LUT_LAST;
    wire  [7:0] lutAddr = hostAddr - lbm_pkg::OFS_LUT_FIRST;

    // Host writes to the parameter bytes and table.
    // Writes to read-only or unmapped addresses fall through and are lost.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            powerLoopTarget     <= lbm_pkg::RESET_BYTE;
            biasTrackingModGain <= lbm_pkg::RESET_BYTE;
            thermalModSlope     <= lbm_pkg::RESET_BYTE;
            thermalModStart     <= lbm_pkg::RESET_BYTE;
            modSetting          <= lbm_pkg::RESET_BYTE;
            biasSetting         <= lbm_pkg::RESET_BYTE;
            trackingSlope       <= lbm_pkg::RESET_BYTE;
            trackingStartTemp   <= lbm_pkg::RESET_BYTE;
        end else if (hostWrite) begin
            case (hostAddr)
                lbm_pkg::OFS_POWER_LOOP_TARGET:
                    powerLoopTarget <= hostWdata;
                lbm_pkg::OFS_BIAS_TRACK_MOD_GAIN:
                    biasTrackingModGain <= hostWdata;
                lbm_pkg::OFS_THERMAL_MOD_SLOPE:
                    thermalModSlope <= hostWdata;
                lbm_pkg::OFS_THERMAL_MOD_START:
                    thermalModStart <= hostWdata;
                lbm_pkg::OFS_MOD_SETTING:
                    modSetting <= hostWdata;
                lbm_pkg::OFS_BIAS_SETTING:
                    biasSetting <= hostWdata;
                lbm_pkg::OFS_TRACKING_SLOPE:
                    trackingSlope <= hostWdata;
                lbm_pkg::OFS_TRACKING_START_TEMP:
                    trackingStartTemp <= hostWdata;
                default: begin
                end
            endcase
        end
    end

    // Table storage has no reset; it is nonvolatile content.
    // Its contents are unknown until the host writes them, so a part
    // enabled with an unwritten entry preloads an unknown bias.
    // The host port writes it; the preload and the read mux read it.
    always_ff @(posedge clk) begin
        if (hostWrite && lutHit) begin
            bias_lookup_table_base[lutAddr[5:0]] <= hostWdata;
        end
    end

    // ==========================================================
    // Table index: temperature code already carries the +40 offset.
    // Dividing by the step gives entry 0 at -40 degrees and entry 35 at
    // +100; hotter codes clip to the last entry rather than run off it.
    wire  [7:0] lutIndexRaw = calibratedTemperature /
                              8'(lbm_pkg::LUT_STEP_DEG);
    wire  [5:0] lutIndex    = (lutIndexRaw >= 8'(LUT_ENTRIES)) ?
                              6'(LUT_ENTRIES - 1) : lutIndexRaw[5:0];

    // ==========================================================
    // Enable sequencing: preload, settle, then closed-loop run.
    // Dropping the enable returns to the off state from anywhere, so a
    // re-enable always starts again with a fresh table preload.
    // The settle count ends the sequence one pre-charge time after the
    // enable is seen, counting the preload and output stages.
    lbm_pkg::lbm_state_t state;
    lbm_pkg::lbm_state_t next_state;
    logic [7:0]          settleCount;
    logic [7:0]          preBias;

    // Next state; a dropped enable overrides every other branch.
    always_comb begin
        next_state = state;
        case (state)
            lbm_pkg::ST_OFF:
                if (txEnable) begin
                    next_state = lbm_pkg::ST_PRELOAD;
                end
            lbm_pkg::ST_PRELOAD:
                next_state = lbm_pkg::ST_SETTLE;
            lbm_pkg::ST_SETTLE:
                if (settleCount ==
                    8'(lbm_pkg::PRECHARGE_CYC - 3)) begin
                    next_state = lbm_pkg::ST_RUN;
                end
            lbm_pkg::ST_RUN:
                next_state = lbm_pkg::ST_RUN;
            default:
                next_state = lbm_pkg::ST_OFF;
        endcase
        if (!txEnable) begin
            next_state = lbm_pkg::ST_OFF;
        end
    end

    // State, settle counter and preloaded bias byte.
    // The table is read once, in the preload state, so later moves of
    // the temperature do not disturb the bias while it settles.
    // The counter idles at zero outside the settle state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state       <= lbm_pkg::ST_OFF;
            settleCount <= 8'h00;
            preBias     <= 8'h00;
        end else begin
            state <= next_state;
            if (state == lbm_pkg::ST_PRELOAD) begin
                preBias <= bias_lookup_table_base[lutIndex];
            end
            if (state == lbm_pkg::ST_SETTLE) begin
                settleCount <= settleCount + 8'h01;
            end else begin
                settleCount <= 8'h00;
            end
        end
    end

    // High once the pre-charge has settled and the loop owns the bias.
    wire running = state == lbm_pkg::ST_RUN;

    // ==========================================================
    // Temperatures after hysteresis, one per feature.
    // Each feature keeps its own held value, and the first reading after
    // reset is taken over at once since it lies far from zero.
    logic [7:0] thermTemp;
    logic [7:0] trackTemp;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            thermTemp <= 8'h00;
            trackTemp <= 8'h00;
        end else begin
            thermTemp <= hyst(thermTemp, calibratedTemperature);
            trackTemp <= hyst(trackTemp, calibratedTemperature);
        end
    end

    // ==========================================================
    // Modulation boosts.
    // The bias boost follows the measured bias current, the thermal
    // boost follows the held temperature above its start point.
    // Integer division truncates; the sum is clipped at full scale.
    wire [25:0] biasProd = biasTrackingModGain *
                           (biasCurrentReading /
                            16'(lbm_pkg::READING_DIV));
    wire [25:0] biasBoost = biasProd / 26'(lbm_pkg::PERCENT);
    wire        thermOn   = thermTemp > thermalModStart;
    wire [7:0]  thermDiff = thermTemp - thermalModStart;
    wire [15:0] thermProd = thermDiff * thermalModSlope;
    wire [15:0] thermBoost = thermOn ?
                             thermProd / 16'(lbm_pkg::PERCENT) : 16'h0;
    wire [26:0] modSum = {19'h0, modSetting} + {1'b0, biasBoost} +
                         {11'h0, thermBoost};
    // Saturate the modulation code rather than let it wrap.
    wire [7:0]  modComp = (modSum > 27'd255) ? 8'hFF : modSum[7:0];

    // ==========================================================
    // Power-loop target scaling with signed tracking slope.
    // The two divisions by one hundred are merged into one by ten
    // thousand after the product, which keeps the small corrections
    // that two separate truncations would lose. A negative slope
    // lowers the target; the result is clipped to the byte range.
    wire               trackOn   = trackTemp > trackingStartTemp;
    wire signed [9:0]  trackDiff = trackOn ?
        $signed({2'b00, trackTemp - trackingStartTemp}) : 10'sd0;
    wire signed [19:0] scaleNum  = trackDiff *
                                   $signed(trackingSlope);
    // The product needs 24 bits at the extremes, so it is kept in 28.
    wire signed [27:0] adjProd   = scaleNum *
                                   $signed({20'h0, powerLoopTarget});
    wire signed [27:0] adjQuot   = adjProd /
        28'(lbm_pkg::PERCENT * lbm_pkg::PERCENT);
    wire signed [19:0] targetAdj = adjQuot[19:0];
    wire [7:0]  targetComp = sat8($signed({12'h0, powerLoopTarget}) +
                                  targetAdj);

    // Bias byte: preload while settling, stored setting once running.
    // The loop integrator sits outside and writes the running setting.
    wire [7:0] biasVal = running ? biasSetting : preBias;

    // ==========================================================
    // Outputs to the laser driver; the two PWM codes are inverted for the filtered PWM.
    // Full code means no current, so reset and the off state park both
    // drive codes at full; the off state keeps the power target and reset clears it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive    <= '{biasPwm: lbm_pkg::PWM_FULL,
                          modPwm: lbm_pkg::PWM_FULL,
                          powerTarget: 8'h00};
            initDone <= 1'b0;
        end else if (state == lbm_pkg::ST_OFF) begin
            drive.biasPwm <= lbm_pkg::PWM_FULL;
            drive.modPwm  <= lbm_pkg::PWM_FULL;
            initDone      <= 1'b0;
        end else begin
            drive.biasPwm     <= lbm_pkg::PWM_FULL - biasVal;
            drive.modPwm      <= lbm_pkg::PWM_FULL - modComp;
            drive.powerTarget <= targetComp;
            initDone          <= running;
        end
    end

    // ==========================================================
    // Host read mux, registered; unmapped bytes read zero.
    // The two bias reading bytes are read live and not latched as a
    // pair, so the host should read them while the bias is steady.
    logic [7:0] next_rdata;

    // Select the addressed byte; the table range is checked first.
    always_comb begin
        next_rdata = 8'h00;
        if (lutHit) begin
            next_rdata = bias_lookup_table_base[lutAddr[5:0]];
        end else begin
            case (hostAddr)
                lbm_pkg::OFS_POWER_LOOP_TARGET:   next_rdata = powerLoopTarget;
                lbm_pkg::OFS_BIAS_TRACK_MOD_GAIN: next_rdata =
                                                    biasTrackingModGain;
                lbm_pkg::OFS_THERMAL_MOD_SLOPE:   next_rdata = thermalModSlope;
                lbm_pkg::OFS_THERMAL_MOD_START:   next_rdata = thermalModStart;
                lbm_pkg::OFS_MOD_SETTING:         next_rdata = modSetting;
                lbm_pkg::OFS_BIAS_SETTING:        next_rdata = biasSetting;
                lbm_pkg::OFS_TRACKING_SLOPE:      next_rdata = trackingSlope;
                lbm_pkg::OFS_TRACKING_START_TEMP: next_rdata =
                                                    trackingStartTemp;
                lbm_pkg::OFS_BIAS_READING_HI:     next_rdata =
                                                    biasCurrentReading[15:8];
                lbm_pkg::OFS_BIAS_READING_LO:     next_rdata =
                                                    biasCurrentReading[7:0];
                lbm_pkg::OFS_CAL_TEMP:            next_rdata =
                                                    calibratedTemperature;
                lbm_pkg::OFS_POWER_TARGET_OUT:    next_rdata = targetComp;
                lbm_pkg::OFS_MOD_OUT:             next_rdata = modComp;
                lbm_pkg::OFS_BIAS_OUT:            next_rdata = biasVal;
                default:                          next_rdata = 8'h00;
            endcase
        end
    end

    // Read data is taken only on a read strobe and then held.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hostRdata <= 8'h00;
        end else if (hostRead) begin
            hostRdata <= next_rdata;
        end
    end

endmodule : lbm_compensation

// File: bench/lbm_compensation_assertions.sv
// Port checker for the laser bias and modulation compensation block.
// Assumes it is bound to lbm_compensation and sees only its ports.
`timescale 1ns/100ps

// =============================================================
// Checker module.
module lbm_compensation_assertions #(
    parameter int LUT_ENTRIES = lbm_pkg::LUT_DEPTH
) (
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                txEnable,
    input wire logic [7:0]          calibratedTemperature,
    input wire logic [15:0]         biasCurrentReading,
    input wire logic                hostWrite,
    input wire logic                hostRead,
    input wire logic [7:0]          hostAddr,
    input wire logic [7:0]          hostWdata,
    input wire logic [7:0]          hostRdata,
    input wire logic                initDone,
    input wire lbm_pkg::lbm_drive_t drive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Enable after a settled off period, and slope byte accesses.
    sequence s_enable;
        !txEnable[*2] ##1 txEnable;
    endsequence
    sequence s_slope_wr;
        hostWrite && hostAddr == lbm_pkg::OFS_THERMAL_MOD_SLOPE;
    endsequence
    sequence s_slope_rd;
        hostRead && hostAddr == lbm_pkg::OFS_THERMAL_MOD_SLOPE;
    endsequence

    property p_off_idle;
        !txEnable[*3] |-> drive.biasPwm == 8'hFF
            && drive.modPwm == 8'hFF && !initDone;
    endproperty
    a_off_idle: assert property (p_off_idle)
        else $error("Outputs not idle while disabled.");
    property p_init_late;
        s_enable |=> !initDone[*8];
    endproperty
    a_init_late: assert property (p_init_late)
        else $error("Init done too early.");
    property p_init_bound;
        s_enable |-> ##[1:25] (initDone || !txEnable);
    endproperty
    a_init_bound: assert property (p_init_bound)
        else $error("Init not done in time.");
    property p_done_enabled;
        initDone |-> $past(txEnable, 2);
    endproperty
    a_done_enabled: assert property (p_done_enabled)
        else $error("Init done without enable.");
    property p_preload_hold;
        s_enable ##4 txEnable |=> ($stable(drive.biasPwm) || !txEnable)[*3];
    endproperty
    a_preload_hold: assert property (p_preload_hold)
        else $error("Preloaded bias moved while settling.");
    property p_rdata_hold;
        !hostRead |=> $stable(hostRdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("Read data changed without a read.");
    property p_unmapped;
        hostRead && hostAddr inside {[8'h34:8'h74]} |=> hostRdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped read not zero.");
    property p_wr_rd;
        s_slope_wr ##2 s_slope_rd |=> hostRdata == $past(hostWdata, 3);
    endproperty
    a_wr_rd: assert property (p_wr_rd)
        else $error("Slope byte readback wrong.");
    property p_reading_hi;
        hostRead && hostAddr == lbm_pkg::OFS_BIAS_READING_HI
            |=> hostRdata == $past(biasCurrentReading[15:8]);
    endproperty
    a_reading_hi: assert property (p_reading_hi)
        else $error("Bias reading high byte wrong.");
endmodule : lbm_compensation_assertions

bind lbm_compensation lbm_compensation_assertions #(
    .LUT_ENTRIES(LUT_ENTRIES)
) u_chk (.clk(clk), .rst(rst), .txEnable(txEnable),
    .calibratedTemperature(calibratedTemperature),
    .biasCurrentReading(biasCurrentReading), .hostWrite(hostWrite),
    .hostRead(hostRead), .hostAddr(hostAddr), .hostWdata(hostWdata),
    .hostRdata(hostRdata), .initDone(initDone), .drive(drive));

// File: bench/lbm_driver_model.sv
// Behavioural laser driver with a bias current monitor.
// Assumes the drive codes are inverted settings from the block.
`timescale 1ns/100ps

// =============================================================
// Driver model.
module lbm_driver_model (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire lbm_pkg::lbm_drive_t drive,
    output logic [15:0]              biasCurrentReading
);
    // The monitor reports four codes per bias step, one cycle late.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            biasCurrentReading <= 16'h0000;
        end else begin
            biasCurrentReading <= {6'h00, 8'hFF - drive.biasPwm, 2'b00};
        end
    end
endmodule : lbm_driver_model

// File: bench/testbench.sv
// Self-checking bench for the compensation block and its driver model.
// Assumes the package and design files are compiled before this one.
`timescale 1ns/100ps

// =============================================================
// Top of the bench.
module testbench;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                txEnable = 1'b0;
    logic [7:0]          temp = 8'h41;
    logic [15:0]         reading;
    logic                hostWrite = 1'b0;
    logic                hostRead = 1'b0;
    logic [7:0]          hostAddr = 8'h00;
    logic [7:0]          hostWdata = 8'h00;
    logic [7:0]          hostRdata;
    logic                initDone;
    lbm_pkg::lbm_drive_t drive;
    int                  bad_count = 0;
    int                  checks_done = 0;
    int                  cycles = 0;
    int                  n;
    logic [7:0]          regAddr [11] = '{8'h02, 8'h04, 8'h05, 8'h06,
        8'h07, 8'h08, 8'h09, 8'h0A, 8'h10, 8'h20, 8'h33};
    logic [7:0]          regData [11] = '{8'hC8, 8'h32, 8'hC8, 8'h3C,
        8'h50, 8'h40, 8'hEC, 8'h3E, 8'h11, 8'h5A, 8'h22};

    lbm_compensation uut (.clk(clk), .rst(rst), .txEnable(txEnable),
        .calibratedTemperature(temp), .biasCurrentReading(reading),
        .hostWrite(hostWrite), .hostRead(hostRead), .hostAddr(hostAddr),
        .hostWdata(hostWdata), .hostRdata(hostRdata),
        .initDone(initDone), .drive(drive));
    lbm_driver_model u_drv (.clk(clk), .rst(rst), .drive(drive),
        .biasCurrentReading(reading));

    // Clock of 25 ns period.
    always #12.5 clk = ~clk;

    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        hostWrite = 1'b1;
        hostAddr = a;
        hostWdata = d;
        tick(1);
        hostWrite = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        tick(1);
        hostRead = 1'b1;
        hostAddr = a;
        tick(1);
        hostRead = 1'b0;
        check(hostRdata, exp);
    endtask : rd

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // Main sequence of accesses and expected values.
    initial begin
        tick(12);
        rst = 1'b0;
        check(drive.biasPwm & drive.modPwm, 8'hFF);
        rd(8'h05, 8'h00);
        for (int i = 0; i < 11; i++) wr(regAddr[i], regData[i]);
        for (int i = 0; i < 11; i++) rd(regAddr[i], regData[i]);
        rd(8'h50, 8'h00);
        wr(8'h05, 8'hC8);
        rd(8'h05, 8'hC8);
        txEnable = 1'b1;
        tick(6);
        check(drive.biasPwm, 8'hA5);
        check({7'h00, initDone}, 8'h00);
        for (n = 6; n < 40 && initDone !== 1'b1; n++) tick(1);
        check({7'h00, n <= 25}, 8'h01);
        tick(10);
        check(drive.biasPwm, 8'hBF);
        check(drive.modPwm, 8'h85);
        check(drive.powerTarget, 8'hC7);
        rd(8'h75, 8'h01);
        rd(8'h76, 8'h00);
        rd(8'h77, 8'h41);
        rd(8'h78, 8'hC7);
        rd(8'h79, 8'h7A);
        rd(8'h7A, 8'h40);
        temp = 8'h42;
        tick(10);
        check(drive.modPwm, 8'h85);
        check(drive.powerTarget, 8'hC7);
        temp = 8'h43;
        tick(10);
        check(drive.modPwm, 8'h81);
        check(drive.powerTarget, 8'hC6);
        wr(8'h06, 8'h50);
        wr(8'h0A, 8'h50);
        tick(4);
        check(drive.modPwm, 8'h8F);
        check(drive.powerTarget, 8'hC8);
        wr(8'h07, 8'hF0);
        tick(10);
        check(drive.modPwm, 8'h00);
        txEnable = 1'b0;
        tick(4);
        check(drive.biasPwm & drive.modPwm, 8'hFF);
        check({7'h00, initDone}, 8'h00);
        give_verdict();
    end
endmodule : testbench
